//--- verilog/peripheral_pin_remap_lock.sv
// Peripheral pin remapping with key-guarded map lock and shadow check.
// Assumes one 25 MHz clock, a plain register port and synchronous pins.
//
// How it works
// - Writes to map registers while locked are dropped, contents kept, and set the blocked-write event.
// - Lock bit 6 of control word blocks map writes when 1.
// - Lock changes only after writes 0x46 then 0x57 to control low byte.
// - Lock holds its value until another keyed write changes it.
// - Shadow copies watched constantly; any difference raises mismatch reset.
// - Session fuse set: lock cannot be cleared once set.
// - Fuse erased reads 1, so only one map session after reset.
// - Fuse programmed 0: lock can be cleared and set repeatedly.
// - Select code 00000 leaves pin on its port logic.
// - Codes 00011 and 00100 give UART transmit and ready-to-send.
// - Codes 00111, 01000, 01001 give SPI data, clock and select.
// - Codes 10010 and 10011 give compare outputs 1 and 2.
// - Mismatch reset sets flag bit 9 of reset cause word.
// - Input select value n takes peripheral input from pin n.
// - Seventeen map registers: nine input and eight output.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_remap_lock
   import pin_remap_pkg::*;
(
   input  wire logic                sys_clk,
   input  wire logic                rst_b,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic      [DATA_W-1:0]   rdata,
   input  wire logic [7:0]          osc_config_word,
   input  wire logic                uart_tx_out,
   input  wire logic                uart_rts_out,
   input  wire logic                spi_data_out,
   input  wire logic                spi_clock_out,
   input  wire logic                spi_select_out,
   input  wire logic                compare_out_1,
   input  wire logic                compare_out_2,
   input  wire logic [N_PIN-1:0]    gpio_out,
   input  wire logic [N_PIN-1:0]    gpio_oe,
   input  wire logic [N_PIN-1:0]    rp_in,
   output logic      [N_PIN-1:0]    rp_out,
   output logic      [N_PIN-1:0]    rp_oe,
   output logic      [N_PIN_IN-1:0] periph_in,
   output logic                     pin_map_lock,
   output logic                     cfg_mismatch_rst,
   output logic                     irq
);

   typedef struct packed {
      logic [N_IMAP-1:0][15:0] imap;
      logic [N_IMAP-1:0][15:0] imap_sh;
      logic [N_OMAP-1:0][15:0] omap;
      logic [N_OMAP-1:0][15:0] omap_sh;
      logic                    lock;
      logic                    set_once;
      key_e                    key_st;
      logic                    cm_flag;
      logic [N_EV-1:0]         irq_st;
      logic [N_EV-1:0]         irq_en;
      logic [DATA_W-1:0]       rdata;
      logic [N_PIN-1:0]        rp_out;
      logic [N_PIN-1:0]        rp_oe;
      logic [N_PIN_IN-1:0]     periph_in;
      logic                    mm_rst;
      logic                    irq;
   } state_s;

   state_s q, d;

   logic              fuse;
   logic              mism;
   logic              is_imap;
   logic              is_omap;
   logic [3:0]        oidx;
   logic [N_PIN-1:0]  mux_out;
   logic [N_PIN-1:0]  mux_oe;
   logic [N_PIN_IN-1:0] mux_in;
   logic [6:0]        periph;

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers
   assign fuse    = osc_config_word[FUSE_BIT];
   assign is_imap = (addr < OMAP_BASE);
   assign is_omap = (addr >= OMAP_BASE) && (addr < OCW_ADDR);
   assign oidx    = 4'(addr - OMAP_BASE);
   assign periph  = {compare_out_2, compare_out_1, spi_select_out,
                     spi_clock_out, spi_data_out, uart_rts_out, uart_tx_out};
   // The shadows only diverge on a cell upset, which logic cannot create
   assign mism    = (q.imap != q.imap_sh) || (q.omap != q.omap_sh);

   ////////////////////////////////////////////////////////////////////////
   // Pin selectors, two fields per map register
   genvar g;
   generate
      for (g = 0; g < N_PIN; g++) begin : g_out
         pin_out_select u_out (
            .sel      (q.omap[g/2][(g%2)*FLD_HI +: FLD_W]),
            .periph   (periph),
            .gpio_out (gpio_out[g]),
            .gpio_oe  (gpio_oe[g]),
            .pin_out  (mux_out[g]),
            .pin_oe   (mux_oe[g])
         );
      end
      for (g = 0; g < N_PIN_IN; g++) begin : g_in
         pin_in_select u_in (
            .sel   (q.imap[g/2][(g%2)*FLD_HI +: FLD_W]),
            .pins  (rp_in),
            .value (mux_in[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      logic [N_EV-1:0] ev;
      logic [N_EV-1:0] clr;
      logic            new_lock;
      ev       = '0;
      clr      = '0;
      new_lock = 1'b0;
      d        = q;
      d.rdata  = '0;
      d.mm_rst = 1'b0;

      if (wr) begin
         if (is_imap) begin
            if (!q.lock) begin
               d.imap[addr[3:0]]    = wdata & MAP_MASK;
               d.imap_sh[addr[3:0]] = wdata & MAP_MASK;
            end else begin
               ev[EV_BLOCK] = 1'b1;
            end
         end else if (is_omap) begin
            if (!q.lock) begin
               d.omap[oidx[2:0]]    = wdata & MAP_MASK;
               d.omap_sh[oidx[2:0]] = wdata & MAP_MASK;
            end else begin
               ev[EV_BLOCK] = 1'b1;
            end
         end else if (addr == OCW_ADDR) begin
            // Any control write that does not advance the key aborts it
            d.key_st = KEY_IDLE;
            case (q.key_st)
               KEY_IDLE: begin
                  if (wdata[7:0] == KEY1) begin
                     d.key_st = KEY_ONE;
                  end
               end
               KEY_ONE: begin
                  if (wdata[7:0] == KEY2) begin
                     d.key_st = KEY_ARMED;
                  end
               end
               KEY_ARMED: begin
                  new_lock = wdata[LOCK_BIT];
                  if (!(fuse && q.set_once && !new_lock)) begin
                     d.lock = new_lock;
                  end
                  if (new_lock) begin
                     d.set_once = 1'b1;
                  end
               end
               default: d.key_st = KEY_IDLE;
            endcase
         end else if (addr == RCW_ADDR) begin
            d.cm_flag = wdata[CM_BIT];
         end else if (addr == IRQ_CLR) begin
            clr = wdata[N_EV-1:0];
         end else if (addr == IRQ_EN) begin
            d.irq_en = wdata[N_EV-1:0];
         end
      end

      // Mismatch reloads the map as a reset would; the flag set wins
      if (mism) begin
         d.mm_rst       = 1'b1;
         d.cm_flag      = 1'b1;
         ev[EV_MISM]    = 1'b1;
         d.imap         = {N_IMAP{IMAP_RST}};
         d.imap_sh      = {N_IMAP{IMAP_RST}};
         d.omap         = {N_OMAP{OMAP_RST}};
         d.omap_sh      = {N_OMAP{OMAP_RST}};
      end

      if (rd) begin
         if (is_imap) begin
            d.rdata = q.imap[addr[3:0]];
         end else if (is_omap) begin
            d.rdata = q.omap[oidx[2:0]];
         end else if (addr == OCW_ADDR) begin
            d.rdata[LOCK_BIT] = q.lock;
         end else if (addr == RCW_ADDR) begin
            d.rdata[CM_BIT] = q.cm_flag;
         end else if (addr == IRQ_STAT) begin
            d.rdata[N_EV-1:0] = q.irq_st;
         end else if (addr == IRQ_EN) begin
            d.rdata[N_EV-1:0] = q.irq_en;
         end
      end

      d.irq_st    = (q.irq_st & ~clr) | ev;
      d.irq       = |(d.irq_st & d.irq_en);
      d.rp_out    = mux_out;
      d.rp_oe     = mux_oe;
      d.periph_in = mux_in;
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q           <= '0;
         q.imap      <= {N_IMAP{IMAP_RST}};
         q.imap_sh   <= {N_IMAP{IMAP_RST}};
         q.omap      <= {N_OMAP{OMAP_RST}};
         q.omap_sh   <= {N_OMAP{OMAP_RST}};
         q.key_st    <= KEY_IDLE;
      end else begin
         q <= d;
      end
   end

   assign rdata            = q.rdata;
   assign rp_out           = q.rp_out;
   assign rp_oe            = q.rp_oe;
   assign periph_in        = q.periph_in;
   assign pin_map_lock     = q.lock;
   assign cfg_mismatch_rst = q.mm_rst;
   assign irq              = q.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   locked_write_a: assert property (
      (wr && addr == IMAP_BASE && q.lock && !mism)
      |=> q.imap[0] == $past(q.imap[0]))
      else $error("locked map write changed register");

   open_write_a: assert property (
      (wr && addr == OMAP_BASE && !q.lock && !mism)
      |=> q.omap[0] == ($past(wdata) & MAP_MASK))
      else $error("unlocked map write not stored");

   lock_key_a: assert property (
      $changed(q.lock) |-> $past(q.key_st) == KEY_ARMED
         && $past(wr) && $past(addr) == OCW_ADDR)
      else $error("lock changed without key");

   lock_hold_a: assert property (
      !(wr && addr == OCW_ADDR) |=> $stable(q.lock))
      else $error("lock moved without control write");

   // Shadow upsets cannot be made from the ports; this stays a guard
   mismatch_rst_a: assert property (
      mism |=> cfg_mismatch_rst ##1 !mism)
      else $error("mismatch reset missing");

   fuse_hold_a: assert property (
      (fuse && q.set_once && q.lock) |=> q.lock)
      else $error("lock cleared under session fuse");

   fuse_free_a: assert property (
      (!fuse && wr && addr == OCW_ADDR && q.key_st == KEY_ARMED
         && !wdata[LOCK_BIT]) |=> !q.lock)
      else $error("lock not cleared with fuse open");

   // Reset loads no mux value, so the edge that releases it is skipped
   out_gpio_a: assert property (
      (rst_b && q.omap[0][4:0] == SEL_GPIO)
      |=> rp_out[0] == $past(gpio_out[0]))
      else $error("default select not port logic");

   gpio_en_a: assert property (
      (rst_b && q.omap[0][4:0] == SEL_GPIO)
      |=> rp_oe[0] == $past(gpio_oe[0]))
      else $error("default select not port enable");

   out_uart_a: assert property (
      (q.omap[1][12:8] == SEL_UTX) |=> rp_out[3] == $past(uart_tx_out))
      else $error("uart transmit not routed");

   out_spi_a: assert property (
      (q.omap[0][12:8] == SEL_SCK) |=> rp_out[1] == $past(spi_clock_out)
         && rp_oe[1])
      else $error("spi clock not routed");

   out_cmp_a: assert property (
      (q.omap[2][4:0] == SEL_CMP2) |=> rp_out[4] == $past(compare_out_2)
         && rp_oe[4])
      else $error("compare 2 not routed");

   cm_flag_a: assert property (
      cfg_mismatch_rst |-> q.cm_flag)
      else $error("mismatch flag not set");

   in_sel_a: assert property (
      (q.imap[0][4:0] == 5'h01) |=> periph_in[0] == $past(rp_in[1]))
      else $error("input select wrong pin");

   key_break_a: assert property (
      (q.key_st == KEY_ONE && wr && addr == OCW_ADDR
         && wdata[7:0] != KEY2) |=> q.key_st == KEY_IDLE)
      else $error("broken key not aborted");

   key_arm_a: assert property (
      (q.key_st == KEY_ONE && wr && addr == OCW_ADDR
         && wdata[7:0] == KEY2) |=> q.key_st == KEY_ARMED)
      else $error("second key not armed");

   fuse_once_a: assert property (
      (fuse && wr && addr == OCW_ADDR && q.key_st == KEY_ARMED
         && wdata[LOCK_BIT]) |=> q.lock && q.set_once)
      else $error("session lock not taken");

   blocked_event_a: assert property (
      (wr && (is_imap || is_omap) && q.lock) |=> q.irq_st[EV_BLOCK])
      else $error("blocked write not flagged");

   omap_hold_a: assert property (
      (wr && is_omap && q.lock && !mism) |=> q.omap == $past(q.omap))
      else $error("locked output map changed");

   last_imap_a: assert property (
      (wr && addr == OMAP_BASE - 5'h01 && !q.lock && !mism)
      |=> q.imap[N_IMAP-1] == ($past(wdata) & MAP_MASK))
      else $error("last input map not stored");

   last_omap_a: assert property (
      (wr && addr == OCW_ADDR - 5'h01 && !q.lock && !mism)
      |=> q.omap[N_OMAP-1] == ($past(wdata) & MAP_MASK))
      else $error("last output map not stored");

   in_none_a: assert property (
      (q.imap[0][4:0] >= FLD_W'(N_PIN)) |=> !periph_in[0])
      else $error("unpinned input not low");

   lock_read_a: assert property (
      (rd && addr == OCW_ADDR) |=> rdata[LOCK_BIT] == $past(q.lock))
      else $error("lock bit read wrong");

endmodule : peripheral_pin_remap_lock
`default_nettype wire

//--- verilog/pin_remap_pkg.sv
// Constants and types shared by the pin remapping block.
// Assumes a 16-bit register port with word addresses.
package pin_remap_pkg;

   localparam int DATA_W  = 16;
   localparam int ADDR_W  = 5;
   localparam int N_IMAP  = 9;
   localparam int N_OMAP  = 8;
   localparam int N_PIN   = 16;
   localparam int N_PIN_IN = 18;
   localparam int FLD_W   = 5;
   localparam int FLD_LO  = 0;
   localparam int FLD_HI  = 8;
   localparam int N_EV    = 2;

   ////////////////////////////////////////////////////////////////////////
   // Register word addresses
   localparam logic [ADDR_W-1:0] IMAP_BASE = 5'h00;
   localparam logic [ADDR_W-1:0] OMAP_BASE = 5'h09;
   localparam logic [ADDR_W-1:0] OCW_ADDR  = 5'h11;
   localparam logic [ADDR_W-1:0] RCW_ADDR  = 5'h12;
   localparam logic [ADDR_W-1:0] IRQ_STAT  = 5'h13;
   localparam logic [ADDR_W-1:0] IRQ_CLR   = 5'h14;
   localparam logic [ADDR_W-1:0] IRQ_EN    = 5'h15;

   ////////////////////////////////////////////////////////////////////////
   // Fields, keys and reset values
   localparam int LOCK_BIT = 6;
   localparam int FUSE_BIT = 5;
   localparam int CM_BIT   = 9;
   localparam int EV_BLOCK = 0;
   localparam int EV_MISM  = 1;
   localparam logic [7:0]  KEY1      = 8'h46;
   localparam logic [7:0]  KEY2      = 8'h57;
   localparam logic [15:0] MAP_MASK  = 16'h1F1F;
   localparam logic [15:0] IMAP_RST  = 16'h1F1F;
   localparam logic [15:0] OMAP_RST  = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // Output select codes
   localparam logic [4:0] SEL_GPIO  = 5'h00;
   localparam logic [4:0] SEL_UTX   = 5'h03;
   localparam logic [4:0] SEL_URTS  = 5'h04;
   localparam logic [4:0] SEL_SDO   = 5'h07;
   localparam logic [4:0] SEL_SCK   = 5'h08;
   localparam logic [4:0] SEL_SS    = 5'h09;
   localparam logic [4:0] SEL_CMP1  = 5'h12;
   localparam logic [4:0] SEL_CMP2  = 5'h13;

   typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_ARMED} key_e;

endpackage : pin_remap_pkg

//--- verilog/pin_out_select.sv
// Output selector for one remappable pin.
// Assumes peripheral outputs are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_out_select
   import pin_remap_pkg::*;
(
   input  wire logic [FLD_W-1:0] sel,
   input  wire logic [6:0]       periph,
   input  wire logic             gpio_out,
   input  wire logic             gpio_oe,
   output logic                  pin_out,
   output logic                  pin_oe
);
   // Unlisted codes fall back to the port logic, never to a floating pin
   always_comb begin
      pin_oe  = 1'b1;
      pin_out = 1'b0;
      case (sel)
         SEL_UTX:  pin_out = periph[0];
         SEL_URTS: pin_out = periph[1];
         SEL_SDO:  pin_out = periph[2];
         SEL_SCK:  pin_out = periph[3];
         SEL_SS:   pin_out = periph[4];
         SEL_CMP1: pin_out = periph[5];
         SEL_CMP2: pin_out = periph[6];
         default: begin
            pin_out = gpio_out;
            pin_oe  = gpio_oe;
         end
      endcase
   end
endmodule : pin_out_select
`default_nettype wire

//--- verilog/pin_in_select.sv
// Input selector for one peripheral input.
// Assumes pin inputs are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_in_select
   import pin_remap_pkg::*;
(
   input  wire logic [FLD_W-1:0] sel,
   input  wire logic [N_PIN-1:0] pins,
   output logic                  value
);
   // Codes above the last pin tie the input low
   always_comb begin
      value = 1'b0;
      if (sel < FLD_W'(N_PIN)) begin
         value = pins[sel[3:0]];
      end
   end
endmodule : pin_in_select
`default_nettype wire

//--- tb/peripheral_pin_remap_lock_tb_top.sv
// Self-checking bench for the pin remapping block with its key-guarded lock.
// Assumes the register port of the block and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; \
   if ((got) !== (exp)) begin err_count++; \
      $display("MISMATCH %s exp %h got %h", nm, (exp), (got)); end end
module peripheral_pin_remap_lock_tb_top
   import pin_remap_pkg::*;
;
   logic                sys_clk;
   logic                rst_b;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                wr;
   logic                rd;
   logic [DATA_W-1:0]   rdata;
   logic [7:0]          osc_cfg;
   logic [6:0]          pv;
   logic [N_PIN-1:0]    gpio_out;
   logic [N_PIN-1:0]    gpio_oe;
   logic [N_PIN-1:0]    rp_in;
   logic [N_PIN-1:0]    rp_out;
   logic [N_PIN-1:0]    rp_oe;
   logic [N_PIN_IN-1:0] periph_in;
   logic                pin_map_lock;
   logic                cfg_mismatch_rst;
   logic                irq;
   int                  err_count;
   int                  total_checks;
   logic [31:0]         seed;
   logic [DATA_W-1:0]   rv;
   logic [DATA_W-1:0]   mem [0:16];
   logic [4:0]          codes [0:8];

   peripheral_pin_remap_lock peripheral_pin_remap_lock_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .osc_config_word(osc_cfg),
      .uart_tx_out(pv[0]), .uart_rts_out(pv[1]), .spi_data_out(pv[2]),
      .spi_clock_out(pv[3]), .spi_select_out(pv[4]),
      .compare_out_1(pv[5]), .compare_out_2(pv[6]),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .rp_in(rp_in),
      .rp_out(rp_out), .rp_oe(rp_oe), .periph_in(periph_in),
      .pin_map_lock(pin_map_lock), .cfg_mismatch_rst(cfg_mismatch_rst),
      .irq(irq));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : nxt

   // Returns {enable, level} expected on a pin for a select code
   function automatic logic [1:0] exp_pin(input logic [4:0] c,
                                          input logic [6:0] v,
                                          input logic go, input logic ge);
      case (c)
         SEL_UTX:  return {1'b1, v[0]};
         SEL_URTS: return {1'b1, v[1]};
         SEL_SDO:  return {1'b1, v[2]};
         SEL_SCK:  return {1'b1, v[3]};
         SEL_SS:   return {1'b1, v[4]};
         SEL_CMP1: return {1'b1, v[5]};
         SEL_CMP2: return {1'b1, v[6]};
         default:  return {ge, go};
      endcase
   endfunction : exp_pin

   function automatic logic exp_in(input logic [4:0] n,
                                   input logic [15:0] p);
      return (n < 5'h10) ? p[n[3:0]] : 1'b0;
   endfunction : exp_in

   task automatic wr_reg(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask : rd_reg

   // Registered outputs lag the map write by one more edge
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic key_seq(input logic [DATA_W-1:0] last);
      wr_reg(OCW_ADDR, 16'h0046);
      wr_reg(OCW_ADDR, 16'h0057);
      wr_reg(OCW_ADDR, last);
      settle();
   endtask : key_seq

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
   endtask : do_reset

   task automatic results();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////
   // Legal traffic never disturbs the map, so no mismatch may appear
   always @(posedge sys_clk) begin
      if (rst_b === 1'b1 && cfg_mismatch_rst !== 1'b0) begin
         err_count++;
         $display("MISMATCH cfg_mismatch_rst exp 0 got %b", cfg_mismatch_rst);
      end
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      $display("MISMATCH watchdog exp done got hang");
      results();
   end

   initial begin
      logic [4:0] n;
      logic [4:0] c;
      logic [4:0] c2;
      rst_b = 1'b0; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
      osc_cfg = 8'hDF; pv = '0; gpio_out = '0; gpio_oe = '0; rp_in = '0;
      err_count = 0; total_checks = 0; seed = 32'ha92a;
      codes = '{SEL_GPIO, SEL_UTX, SEL_URTS, SEL_SDO, SEL_SCK, SEL_SS,
                SEL_CMP1, SEL_CMP2, 5'h01};
      @(posedge sys_clk);
      #1;
      `CHK("rp_oe in reset", 16'h0000, rp_oe)
      @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      `CHK("lock after reset", 1'b0, pin_map_lock)
      for (int i = 0; i < 17; i++) begin
         rd_reg(ADDR_W'(i));
         `CHK("map reset", (i < N_IMAP) ? IMAP_RST : OMAP_RST, rv)
      end
      rd_reg(RCW_ADDR);
      `CHK("mismatch flag", 1'b0, rv[CM_BIT])
      wr_reg(5'h16, 16'(nxt()));
      rd_reg(5'h16);
      `CHK("unmapped", 16'h0000, rv)
      for (int i = 0; i < 17; i++) begin
         mem[i] = 16'(nxt());
         wr_reg(ADDR_W'(i), mem[i]);
         mem[i] = mem[i] & MAP_MASK;
         rd_reg(ADDR_W'(i));
         `CHK("map write", mem[i], rv)
      end
      // Input routing, field 31 included as a no-pin value
      for (int i = 0; i < 8; i++) begin
         n  = (i == 0) ? 5'h1F : (i == 1) ? 5'h01 : 5'(nxt());
         c2 = {1'b0, 4'(nxt())};
         wr_reg(IMAP_BASE, {3'b0, c2, 3'b0, n});
         rp_in <= 16'(nxt());
         settle();
         `CHK("periph_in lo", exp_in(n, rp_in), periph_in[0])
         `CHK("periph_in hi", exp_in(c2, rp_in), periph_in[1])
      end
      // Every output code on both fields of the first output map
      for (int i = 0; i < 9; i++) begin
         c  = codes[i];
         c2 = codes[(i + 4) % 9];
         @(posedge sys_clk);
         pv       <= 7'(nxt());
         gpio_out <= 16'(nxt());
         gpio_oe  <= 16'(nxt());
         // The next two maps carry the routes that the checks watch
         wr_reg(OMAP_BASE, {3'b0, c2, 3'b0, c});
         wr_reg(OMAP_BASE + 5'h01, {3'b0, c2, 3'b0, c});
         wr_reg(OMAP_BASE + 5'h02, {3'b0, c2, 3'b0, c});
         settle();
         `CHK("pin0", exp_pin(c, pv, gpio_out[0], gpio_oe[0]),
              {rp_oe[0], rp_out[0]})
         `CHK("pin1", exp_pin(c2, pv, gpio_out[1], gpio_oe[1]),
              {rp_oe[1], rp_out[1]})
      end
      mem[OMAP_BASE] = {3'b0, codes[3], 3'b0, codes[8]};
      // Broken sequence, then one with a foreign write in between
      wr_reg(OCW_ADDR, 16'h0046);
      wr_reg(OCW_ADDR, 16'h0011);
      wr_reg(OCW_ADDR, 16'h0057);
      wr_reg(OCW_ADDR, 16'h0040);
      settle();
      `CHK("aborted key", 1'b0, pin_map_lock)
      wr_reg(OCW_ADDR, 16'h0046);
      wr_reg(RCW_ADDR, 16'h0000);
      wr_reg(OCW_ADDR, 16'h0057);
      // A write elsewhere between the keys leaves the sequence in progress
      wr_reg(OCW_ADDR, 16'h0040);
      settle();
      `CHK("lock set", 1'b1, pin_map_lock)
      rd_reg(OCW_ADDR);
      `CHK("lock read", 1'b1, rv[LOCK_BIT])
      wr_reg(5'h03, ~mem[3]);
      rd_reg(5'h03);
      `CHK("locked imap", mem[3], rv)
      settle();
      `CHK("irq masked", 1'b0, irq)
      rd_reg(IRQ_STAT);
      `CHK("blocked status", 1'b1, rv[EV_BLOCK])
      wr_reg(IRQ_EN, 16'h0001);
      settle();
      `CHK("irq raised", 1'b1, irq)
      wr_reg(IRQ_CLR, 16'h0001);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      wr_reg(OMAP_BASE, ~mem[OMAP_BASE]);
      rd_reg(OMAP_BASE);
      `CHK("locked omap", mem[OMAP_BASE], rv)
      key_seq(16'h0000);
      `CHK("unlock", 1'b0, pin_map_lock)
      wr_reg(5'h03, 16'h0102);
      rd_reg(5'h03);
      `CHK("reopened map", 16'h0102, rv)
      key_seq(16'h0040);
      key_seq(16'h0000);
      `CHK("second unlock", 1'b0, pin_map_lock)
      // Erased fuse: one session only
      @(posedge sys_clk);
      osc_cfg <= 8'hFF;
      do_reset();
      key_seq(16'h0040);
      `CHK("fuse lock", 1'b1, pin_map_lock)
      key_seq(16'h0000);
      `CHK("fuse keeps lock", 1'b1, pin_map_lock)
      wr_reg(IMAP_BASE, 16'h0000);
      rd_reg(IMAP_BASE);
      `CHK("fuse map", IMAP_RST, rv)
      results();
   end
endmodule : peripheral_pin_remap_lock_tb_top
`default_nettype wire
